// File: rtl/ocd_defs.vh
// opcode decoder constants: field positions, timing counts, mode reset value
// assumes inclusion by every design file of the opcode cycle decoder
`ifndef OCD_DEFS_VH
`define OCD_DEFS_VH
`define OCD_LEN_W 2
`define OCD_CYC_W 3
`define OCD_MODE_1T_BIT 7
`define OCD_IFC_RESET 8'h00
`define OCD_CLK_2T 2'h2
`define OCD_CLK_1T 2'h1
`endif

// File: rtl/ocd_len_rom.v
// opcode table: bytes and machine cycles for each of 256 opcodes
// assumes opcode presented on the same clock; answer is registered
`timescale 1ns/1ps
`include "ocd_defs.vh"
module ocd_len_rom (
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [7:0] opcode,
  output reg [1:0] len_q,
  output reg [2:0] cyc_q
);
  reg [4:0] ent;
  // --------------------------------------------------------
  // table lookup, packed as {bytes, cycles}
  // --------------------------------------------------------
  always @* begin
    ent = {2'h1, 3'h1};
    casez (opcode)
      8'b???1_0001: ent = {2'h2, 3'h6};
      8'b???0_0001: ent = {2'h2, 3'h3};
      8'h58, 8'h59, 8'h5A, 8'h5B, 8'h5C, 8'h5D, 8'h5E, 8'h5F,
      8'h48, 8'h49, 8'h4A, 8'h4B, 8'h4C, 8'h4D, 8'h4E, 8'h4F,
      8'h68, 8'h69, 8'h6A, 8'h6B, 8'h6C, 8'h6D, 8'h6E, 8'h6F:
        ent = {2'h1, 3'h1};
      8'h55, 8'h45, 8'h65, 8'h54, 8'h44, 8'h64: ent = {2'h2, 3'h2};
      8'h56, 8'h57, 8'h46, 8'h47, 8'h66, 8'h67: ent = {2'h1, 3'h2};
      8'h52, 8'h42, 8'h62: ent = {2'h2, 3'h3};
      8'h53, 8'h43, 8'h63: ent = {2'h3, 3'h4};
      8'hE4, 8'hF4, 8'h23, 8'h33, 8'h03, 8'h13, 8'hC4:
        ent = {2'h1, 3'h1};
      8'hE8, 8'hE9, 8'hEA, 8'hEB, 8'hEC, 8'hED, 8'hEE, 8'hEF:
        ent = {2'h1, 3'h1};
      8'hF8, 8'hF9, 8'hFA, 8'hFB, 8'hFC, 8'hFD, 8'hFE, 8'hFF,
      8'hC8, 8'hC9, 8'hCA, 8'hCB, 8'hCC, 8'hCD, 8'hCE, 8'hCF:
        ent = {2'h1, 3'h2};
      8'hE5, 8'h74, 8'h78, 8'h79, 8'h7A, 8'h7B, 8'h7C, 8'h7D,
      8'h7E, 8'h7F: ent = {2'h2, 3'h2};
      8'hA8, 8'hA9, 8'hAA, 8'hAB, 8'hAC, 8'hAD, 8'hAE, 8'hAF,
      8'h86, 8'h87: ent = {2'h2, 3'h4};
      8'hE6, 8'hE7: ent = {2'h1, 3'h2};
      8'hF5, 8'h88, 8'h89, 8'h8A, 8'h8B, 8'h8C, 8'h8D, 8'h8E,
      8'h8F, 8'hC5, 8'hC2, 8'hD2, 8'hB2, 8'h92:
        ent = {2'h2, 3'h3};
      8'h85: ent = {2'h3, 3'h4};
      8'h75: ent = {2'h3, 3'h3};
      8'hF6, 8'hF7, 8'hC6, 8'hC7: ent = {2'h1, 3'h3};
      8'h76, 8'h77: ent = {2'h2, 3'h3};
      8'hA6, 8'hA7: ent = {2'h2, 3'h5};
      8'h90: ent = {2'h3, 3'h3};
      8'h93, 8'h83: ent = {2'h1, 3'h3};
      8'hE0, 8'hE2, 8'hE3: ent = {2'h1, 3'h3};
      8'hF0, 8'hF2, 8'hF3: ent = {2'h1, 3'h4};
      8'hC0: ent = {2'h2, 3'h4};
      8'hD0: ent = {2'h2, 3'h3};
      8'hD6, 8'hD7: ent = {2'h1, 3'h3};
      8'h12: ent = {2'h3, 3'h6};
      8'h22, 8'h32: ent = {2'h1, 3'h4};
      8'h02: ent = {2'h3, 3'h4};
      8'h80: ent = {2'h2, 3'h3};
      8'h73: ent = {2'h1, 3'h2};
      8'h60, 8'h70, 8'h40, 8'h50: ent = {2'h2, 3'h3};
      8'h20, 8'h30, 8'h10: ent = {2'h3, 3'h4};
      8'hB4, 8'hB5, 8'hB6, 8'hB7, 8'hB8, 8'hB9, 8'hBA, 8'hBB,
      8'hBC, 8'hBD, 8'hBE, 8'hBF: ent = {2'h3, 3'h4};
      8'hD8, 8'hD9, 8'hDA, 8'hDB, 8'hDC, 8'hDD, 8'hDE, 8'hDF:
        ent = {2'h2, 3'h3};
      8'hD5: ent = {2'h3, 3'h4};
      8'h82, 8'hB0, 8'h72, 8'hA0, 8'hA2: ent = {2'h2, 3'h2};
      default: ent = {2'h1, 3'h1};
    endcase
  end

  // registered answer
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      len_q <= 2'h1;
      cyc_q <= 3'h1;
    end else if (clk_en) begin
      len_q <= ent[4:3];
      cyc_q <= ent[2:0];
    end
  end
endmodule // ocd_len_rom

// File: rtl/ocd_core.v
// instruction fetch and cycle sequencer for the 8-bit core
// assumes program memory answers a read in the cycle after the request
`timescale 1ns/1ps
`include "ocd_defs.vh"
module ocd_core #(
  parameter PC_W = 16
) (
  input wire ref_clk,
  input wire rst_n,
  input wire clk_en,
  input wire [7:0] interface_control_register,
  input wire [7:0] code_rdata,
  input wire bit_value,
  output wire [PC_W-1:0] code_addr,
  output wire code_rd,
  output reg [7:0] opcode_q,
  output reg [7:0] operand1_q,
  output reg [7:0] operand2_q,
  output reg [1:0] length_q,
  output reg [2:0] mcycles_q,
  output reg insn_done_q,
  output reg bit_clear_q,
  output reg [PC_W-1:0] pc_q
);
  localparam ST_OPC = 6'b000001;
  localparam ST_DEC = 6'b000010;
  localparam ST_LEN = 6'b000100;
  localparam ST_OPR = 6'b001000;
  localparam ST_OPD = 6'b010000;
  localparam ST_EXE = 6'b100000;

  reg [5:0] st_q;
  reg [5:0] st_d;
  reg [1:0] got_q;
  reg [2:0] mc_q;
  reg [1:0] tick_q;
  wire [1:0] rom_len;
  wire [2:0] rom_cyc;
  wire [1:0] clk_per_mc;
  wire mc_end;

  ocd_len_rom u_rom (
    .ref_clk(ref_clk),
    .rst_n(rst_n),
    .clk_en(clk_en),
    .opcode(code_rdata),
    .len_q(rom_len),
    .cyc_q(rom_cyc)
  );

  // --------------------------------------------------------
  // machine cycle timing
  // --------------------------------------------------------
  // mode bit picks clocks
  assign clk_per_mc =
    interface_control_register[`OCD_MODE_1T_BIT] ? `OCD_CLK_1T :
    `OCD_CLK_2T;
  assign mc_end = (tick_q + 2'h1 >= clk_per_mc);

  // ticks within the current machine cycle
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      tick_q <= 2'h0;
    end else if (clk_en) begin
      if (st_q != ST_EXE || mc_end) begin
        tick_q <= 2'h0;
      end else begin
        tick_q <= tick_q + 2'h1;
      end
    end
  end

  // --------------------------------------------------------
  // fetch address
  // --------------------------------------------------------
  // consecutive fetch, pc advances
  assign code_addr = pc_q;
  assign code_rd = (st_q == ST_OPC) || (st_q == ST_OPR);

  // next state; a byte is asked for in one state and taken in the next,
  // because program memory answers one live edge after the request
  always @* begin
    st_d = st_q;
    case (st_q)
      ST_OPC: st_d = ST_DEC;
      ST_DEC: st_d = ST_LEN;
      // table answer is registered, so it is only valid in this state
      ST_LEN: st_d = (rom_len > 2'h1) ? ST_OPR : ST_EXE;
      ST_OPR: st_d = ST_OPD;
      ST_OPD: st_d = (got_q + 2'h1 < length_q) ? ST_OPR : ST_EXE;
      // the sequencer counts machine cycles from operand fetch end;
      // this keeps the count a plain per-instruction figure
      ST_EXE: st_d = (mc_end && mc_q + 3'h1 >= mcycles_q) ?
        ST_OPC : ST_EXE;
      default: st_d = ST_OPC;
    endcase
  end

  // --------------------------------------------------------
  // sequencer registers
  // --------------------------------------------------------
  always @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_OPC;
      pc_q <= {PC_W{1'b0}};
      got_q <= 2'h0;
      mc_q <= 3'h0;
      opcode_q <= 8'h00;
      operand1_q <= 8'h00;
      operand2_q <= 8'h00;
      length_q <= 2'h1;
      mcycles_q <= 3'h1;
      insn_done_q <= 1'b0;
      bit_clear_q <= 1'b0;
    end else if (clk_en) begin
      st_q <= st_d;
      insn_done_q <= 1'b0;
      bit_clear_q <= 1'b0;
      case (st_q)
        ST_OPC: begin
          pc_q <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
        end
        ST_DEC: begin
          opcode_q <= code_rdata;
        end
        ST_LEN: begin
          length_q <= rom_len;
          mcycles_q <= rom_cyc;
          got_q <= 2'h1;
          mc_q <= 3'h0;
        end
        ST_OPR: begin
          pc_q <= pc_q + {{(PC_W-1){1'b0}}, 1'b1};
        end
        ST_OPD: begin
          if (got_q == 2'h1) begin
            operand1_q <= code_rdata;
          end else begin
            operand2_q <= code_rdata;
          end
          got_q <= got_q + 2'h1;
        end
        ST_EXE: begin
          if (mc_end) begin
            mc_q <= mc_q + 3'h1;
          end
          if (st_d == ST_OPC) begin
            insn_done_q <= 1'b1;
            bit_clear_q <= (opcode_q == 8'h10) && bit_value;
          end
        end
        default: begin
          mc_q <= 3'h0;
        end
      endcase
    end
  end
endmodule // ocd_core

// File: test/ocd_core_props.sv
// checks on ocd_core ports: reset state, done pulse, stalls, decode
// assumes binding into ocd_core; one clock ref_clk, async rst_n
`timescale 1ns/1ps
module ocd_core_props #(
  parameter PC_W = 16
) (
  input logic ref_clk,
  input logic rst_n,
  input logic clk_en,
  input logic bit_value,
  input logic code_rd,
  input logic [7:0] opcode_q,
  input logic [1:0] length_q,
  input logic [2:0] mcycles_q,
  input logic insn_done_q,
  input logic bit_clear_q,
  input logic [PC_W-1:0] pc_q
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  // each ties an output to its cause; stalls must hold pc_q and insn_done_q
  rst_fetch_a: assert property ($rose(rst_n) |-> code_rd
    && pc_q == '0 && length_q == 2'h1 && mcycles_q == 3'h1)
    else $error("bad state after reset");
  done_pulse_a: assert property (insn_done_q && clk_en |=> !insn_done_q)
    else $error("done held too long");
  freeze_a: assert property (!clk_en |=>
    $stable(pc_q) && $stable(insn_done_q)) else $error("moved in stall");
  fetch_next_a: assert property (insn_done_q && clk_en
    |-> ##[0:1] code_rd) else $error("no fetch after done");
  clear_cause_a: assert property (bit_clear_q |-> insn_done_q &&
    opcode_q == 8'h10 && bit_value) else $error("stray bit clear");
  clear_taken_a: assert property (insn_done_q && opcode_q == 8'h10
    && bit_value |-> bit_clear_q) else $error("bit clear missing");
  call_six_a: assert property (insn_done_q && opcode_q == 8'h12 |->
    length_q == 2'h3 && mcycles_q == 3'h6) else $error("call decode");
  ind_five_a: assert property (insn_done_q && opcode_q == 8'hA6 |->
    length_q == 2'h2 && mcycles_q == 3'h5) else $error("move decode");
endmodule // ocd_core_props
bind ocd_core ocd_core_props #(.PC_W(PC_W)) props_u (.*);

// File: test/ocd_code_mem.sv
// code memory model: answers a fetch one clock after code_rd
// assumes the bench preloads mem before reset is released
`timescale 1ns/1ps
module ocd_code_mem (
  input logic ref_clk,
  input logic clk_en,
  input logic code_rd,
  input logic [15:0] code_addr,
  output logic [7:0] code_rdata = 8'h00
);
  logic [7:0] mem [256] = '{default: 8'h00};
  // idle cycles invert the byte so a stale read never looks good
  // a stalled edge takes no request and keeps the byte on the bus
  always @(posedge ref_clk) begin
    if (clk_en) begin
      if (code_rd) code_rdata <= mem[code_addr[7:0]];
      else code_rdata <= ~code_rdata;
    end
  end
endmodule // ocd_code_mem

// File: test/mcu_opcode_cycle_decoder_bench.sv
// bench: decoded bytes, cycles and operand order of ocd_core
// assumes ocd_code_mem on the fetch port, ocd_core_props bound in
`timescale 1ns/1ps
module mcu_opcode_cycle_decoder_bench;
  localparam int N = 52;
  logic ref_clk = 0, rst_n = 0, clk_en = 1, bit_value = 0;
  logic [7:0] interface_control_register = 8'h00;
  wire [15:0] code_addr, pc_q;
  wire [7:0] code_rdata, opcode_q, operand1_q, operand2_q;
  wire [1:0] length_q;
  wire [2:0] mcycles_q;
  wire code_rd, insn_done_q, bit_clear_q;
  int errors = 0, comparisons = 0, gap2 [N];
  // program: opcode, byte count, machine cycles per entry
  logic [15:0] tbl [N] = '{
    16'h5811,16'h4811,16'h6811,16'h5522,16'h4522,16'h6522,
    16'h5612,16'h4612,16'h6612,16'h5223,16'h4223,16'h6223,
    16'h5334,16'h4334,16'h6334,16'hE411,16'hF411,16'hC411,
    16'hE811,16'hFF12,16'hA824,16'h8534,
    16'hA625,16'h9033,16'h9313,16'h8313,
    16'hE013,16'hF014,16'hE213,16'hC024,16'hD023,
    16'hD613,16'h1236,16'h1126,
    16'h8023,16'h0123,16'h0234,16'h6023,16'h7023,16'h4023,
    16'h2034,16'h3034,16'h1034,16'hB434,16'hB834,16'hB634,
    16'hD823,16'hD534,16'h8222,16'h7222,16'hA022,16'h9223};
  ocd_core dut_u (.*);
  ocd_code_mem mem_u (.*);
  initial forever #2.5 ref_clk = ~ref_clk;
  initial begin
    repeat (20000) @(posedge ref_clk); // both passes need about 1200
    errors++;
    end_of_test();
  end
  task end_of_test();
    if (errors == 0 && comparisons > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  task chk(input logic [15:0] seen, input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      errors++;
      $display("unexpected %0t: saw %h want %h", $time, seen, exp);
    end
  endtask
  // one pass; clk_en drops one cycle in five, only live edges count
  task automatic run(input logic [7:0] mode, input logic bv, input bit t1);
    int k = 0, a = 0, n = 0, w = 0;
    @(posedge ref_clk);
    {rst_n, clk_en} <= 2'b01;
    {interface_control_register, bit_value} <= {mode, bv};
    repeat (2) @(posedge ref_clk);
    rst_n <= 1'b1;
    while (k < N && w < 300) begin
      @(posedge ref_clk);
      w++;
      n += clk_en;
      if (clk_en && insn_done_q === 1'b1) begin
        chk({opcode_q, 2'h0, length_q, 1'h0, mcycles_q}, tbl[k]);
        if (tbl[k][5:4] > 1) chk(operand1_q, 8'(a + 1) ^ 8'hA5);
        if (tbl[k][5:4] > 2) chk(operand2_q, 8'(a + 2) ^ 8'hA5);
        chk(pc_q, 16'(a + tbl[k][5:4]));
        chk(bit_clear_q, tbl[k][15:8] == 8'h10 && bv);
        if (t1) chk(16'(gap2[k] - n), tbl[k][2:0]);
        else gap2[k] = n;
        a += tbl[k][5:4];
        k++;
        {n, w} = '0;
      end
      clk_en <= (w % 5 != 3);
    end
    chk(16'(k), 16'(N));
  endtask
  // 2T with other control bits set and tested bit high, then 1T
  task two_t_table();
    run(8'h7F, 1'b1, 1'b0);
  endtask
  task one_t_timing();
    run(8'h80, 1'b0, 1'b1);
  endtask
  initial begin
    int a = 0;
    for (int k = 0; k < N; k++)
      for (int j = 0; j < tbl[k][5:4]; j++, a++)
        mem_u.mem[a] = j ? 8'(a) ^ 8'hA5 : tbl[k][15:8];
    two_t_table();
    one_t_timing();
    end_of_test();
  end
endmodule // mcu_opcode_cycle_decoder_bench
